// ### rtl/crri_core_register_reset_init.sv
// Purpose: core special function registers with reset-class and wake-up initialisation
// Assumes: reset-class and wake inputs are one-cycle pulses from core logic on clk
// Notes: undefined power-up contents are modelled as zero, a legal choice of unknown
//
// Summary of operation
// - stack top bytes cleared on every hard or power reset, held on wake-up unless loaded by an enabled interrupt wake
// - power reset keeps stack flags, zeroes pointer; hard reset clears all; bit5 zero
// - pc latches and low byte cleared on reset; wake-up advances pc by two unless the interrupt wake is vectored
// - table pointer and table latch cleared on reset, held on wake-up
// - product, accumulator, pointer bytes undefined at power-up, else kept
// - main interrupt control clears bits 7..1; bit0 undefined or kept
// - second interrupt control set to all ones on any reset
// - third interrupt control set to 1100_0000 on any reset
// - interrupt wake with global enable copies pc into stack top
// - interrupt wake with global enable advances the stack pointer
// - interrupt wake with global enable loads high or low vector
// - wake-up leaves the causing interrupt flag set
// - indirect alias locations own no storage and no reset value
// - unimplemented bits read as zero
// - first port bits 6 and 7 usable only in freeing oscillator modes
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module crri_core_register_reset_init
  import crri_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic power_reset, // power-on or brown-out event pulse
  input wire logic hard_reset, // other hard reset event pulse
  input wire logic wake_watchdog, // wake-up by watchdog pulse
  input wire logic wake_interrupt, // wake-up by interrupt pulse
  input wire logic wake_high_priority, // interrupt wake is high priority
  input wire logic [7:0] wake_flags, // main control flag bits causing wake
  input wire logic [20:0] pc_current, // program counter of the sleep instruction
  input wire logic osc_frees_pins, // oscillator mode frees port bits 6 and 7
  input wire logic [7:0] first_port_pins, // first port pin levels, asynchronous
  input wire logic [4:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_write, // write strobe
  input wire logic reg_read, // read strobe
  output logic [7:0] reg_rdata, // read data, valid cycle after read strobe
  output logic [20:0] pc_out, // program counter
  output logic [7:0] port_latch_out, // first port output latch
  output logic [7:0] port_direction_out // first port direction
);

  typedef struct packed {
    logic [4:0] stack_top_upper;
    logic [7:0] stack_top_high;
    logic [7:0] stack_top_low;
    logic [7:0] return_stack_pointer;
    logic [4:0] program_counter_upper_latch;
    logic [7:0] program_counter_high_latch;
    logic [20:0] pc;
    logic [5:0] table_pointer_upper;
    logic [7:0] table_pointer_high;
    logic [7:0] table_pointer_low;
    logic [7:0] table_data_latch;
    logic [7:0] multiply_result_high;
    logic [7:0] multiply_result_low;
    logic [7:0] interrupt_control_main;
    logic [7:0] interrupt_control_second;
    logic [7:0] interrupt_control_third;
    logic [3:0] pointer_zero_high;
    logic [7:0] pointer_zero_low;
    logic [7:0] working_accumulator;
    logic [7:0] first_port_latch;
    logic [7:0] first_port_direction;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] rdata;
  } crri_state_t;

  crri_state_t st;
  crri_state_t next_st;
  logic [7:0] port_mask;
  logic [7:0] read_value;
  logic int_wake_vectored;

  // disabled pins read and hold as zero
  assign port_mask = osc_frees_pins ? 8'hFF : MASK_PORT_NARROW;

  assign int_wake_vectored = wake_interrupt &&
    (st.interrupt_control_main[GLOBAL_HIGH_ENABLE_BIT] ||
     st.interrupt_control_main[GLOBAL_LOW_ENABLE_BIT]);

  always_comb
  begin
    read_value = RESET_ZERO;
    unique case (reg_addr)
      ADDR_STACK_TOP_UPPER: read_value = {3'h0, st.stack_top_upper};
      ADDR_STACK_TOP_HIGH: read_value = st.stack_top_high;
      ADDR_STACK_TOP_LOW: read_value = st.stack_top_low;
      ADDR_RETURN_STACK_POINTER: read_value = st.return_stack_pointer & MASK_STACK_POINTER;
      ADDR_PC_UPPER_LATCH: read_value = {3'h0, st.program_counter_upper_latch};
      ADDR_PC_HIGH_LATCH: read_value = st.program_counter_high_latch;
      ADDR_PC_LOW_BYTE: read_value = st.pc[7:0];
      ADDR_TABLE_POINTER_UPPER: read_value = {2'h0, st.table_pointer_upper};
      ADDR_TABLE_POINTER_HIGH: read_value = st.table_pointer_high;
      ADDR_TABLE_POINTER_LOW: read_value = st.table_pointer_low;
      ADDR_TABLE_DATA_LATCH: read_value = st.table_data_latch;
      ADDR_MULTIPLY_RESULT_HIGH: read_value = st.multiply_result_high;
      ADDR_MULTIPLY_RESULT_LOW: read_value = st.multiply_result_low;
      ADDR_INTERRUPT_CONTROL_MAIN: read_value = st.interrupt_control_main;
      ADDR_INTERRUPT_CONTROL_SECOND: read_value = st.interrupt_control_second;
      ADDR_INTERRUPT_CONTROL_THIRD: read_value = st.interrupt_control_third;
      ADDR_POINTER_ZERO_HIGH: read_value = {4'h0, st.pointer_zero_high};
      ADDR_POINTER_ZERO_LOW: read_value = st.pointer_zero_low;
      ADDR_WORKING_ACCUMULATOR: read_value = st.working_accumulator;
      ADDR_FIRST_PORT_INPUT: read_value = st.pin_sync & port_mask;
      ADDR_FIRST_PORT_LATCH: read_value = st.first_port_latch & port_mask;
      ADDR_FIRST_PORT_DIRECTION: read_value = st.first_port_direction & port_mask;
      // alias locations and unmapped indices hold nothing and read zero
      default: read_value = RESET_ZERO;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.pin_meta = first_port_pins;
    next_st.pin_sync = st.pin_meta;
    next_st.rdata = reg_read ? read_value : RESET_ZERO;
    if (reg_write)
    begin
      unique case (reg_addr)
        ADDR_STACK_TOP_UPPER: next_st.stack_top_upper = reg_wdata[4:0];
        ADDR_STACK_TOP_HIGH: next_st.stack_top_high = reg_wdata;
        ADDR_STACK_TOP_LOW: next_st.stack_top_low = reg_wdata;
        ADDR_RETURN_STACK_POINTER: next_st.return_stack_pointer = reg_wdata & MASK_STACK_POINTER;
        ADDR_PC_UPPER_LATCH: next_st.program_counter_upper_latch = reg_wdata[4:0];
        ADDR_PC_HIGH_LATCH: next_st.program_counter_high_latch = reg_wdata;
        // a low-byte write jumps, taking the upper bits from the latches
        ADDR_PC_LOW_BYTE: next_st.pc = {st.program_counter_upper_latch,
                                         st.program_counter_high_latch, reg_wdata};
        ADDR_TABLE_POINTER_UPPER: next_st.table_pointer_upper = reg_wdata[5:0];
        ADDR_TABLE_POINTER_HIGH: next_st.table_pointer_high = reg_wdata;
        ADDR_TABLE_POINTER_LOW: next_st.table_pointer_low = reg_wdata;
        ADDR_TABLE_DATA_LATCH: next_st.table_data_latch = reg_wdata;
        ADDR_MULTIPLY_RESULT_HIGH: next_st.multiply_result_high = reg_wdata;
        ADDR_MULTIPLY_RESULT_LOW: next_st.multiply_result_low = reg_wdata;
        ADDR_INTERRUPT_CONTROL_MAIN: next_st.interrupt_control_main = reg_wdata;
        ADDR_INTERRUPT_CONTROL_SECOND: next_st.interrupt_control_second = reg_wdata;
        ADDR_INTERRUPT_CONTROL_THIRD: next_st.interrupt_control_third = reg_wdata;
        ADDR_POINTER_ZERO_HIGH: next_st.pointer_zero_high = reg_wdata[3:0];
        ADDR_POINTER_ZERO_LOW: next_st.pointer_zero_low = reg_wdata;
        ADDR_WORKING_ACCUMULATOR: next_st.working_accumulator = reg_wdata;
        ADDR_FIRST_PORT_LATCH: next_st.first_port_latch = reg_wdata & port_mask;
        ADDR_FIRST_PORT_DIRECTION: next_st.first_port_direction = reg_wdata & port_mask;
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // disabled bits are forced low so they never drive or read back
    next_st.first_port_latch = next_st.first_port_latch & port_mask;
    next_st.first_port_direction = next_st.first_port_direction & port_mask;
    // wake-up: flags set after any write so a same-cycle write never clears the cause; a same-cycle reset still does
    if (wake_watchdog || wake_interrupt)
    begin
      next_st.interrupt_control_main = next_st.interrupt_control_main | wake_flags;
      next_st.pc = pc_current + SLEEP_STEP;
      if (int_wake_vectored)
      begin
        next_st.stack_top_upper = pc_current[20:16];
        next_st.stack_top_high = pc_current[15:8];
        next_st.stack_top_low = pc_current[7:0];
        next_st.return_stack_pointer = (st.return_stack_pointer & STACK_FLAGS_MASK) |
          ((st.return_stack_pointer + 8'h01) & STACK_INDEX_MASK);
        next_st.pc = wake_high_priority ? VECTOR_HIGH : VECTOR_LOW;
      end
    end
    // reset classes win over everything else in the same cycle
    if (power_reset || hard_reset)
    begin
      next_st.stack_top_upper = 5'h00;
      next_st.stack_top_high = RESET_ZERO;
      next_st.stack_top_low = RESET_ZERO;
      next_st.program_counter_upper_latch = 5'h00;
      next_st.program_counter_high_latch = RESET_ZERO;
      next_st.pc = 21'h000000;
      next_st.table_pointer_upper = 6'h00;
      next_st.table_pointer_high = RESET_ZERO;
      next_st.table_pointer_low = RESET_ZERO;
      next_st.table_data_latch = RESET_ZERO;
      next_st.interrupt_control_second = RESET_INTERRUPT_SECOND;
      next_st.interrupt_control_third = RESET_INTERRUPT_THIRD;
      // bit0 kept on hard reset; unknown on power reset, kept too
      next_st.interrupt_control_main = st.interrupt_control_main &
        INTERRUPT_MAIN_KEEP_MASK;
      // product, accumulator and pointer bytes are simply not touched
      if (power_reset)
        next_st.return_stack_pointer = st.return_stack_pointer & STACK_FLAGS_MASK;
      else
        next_st.return_stack_pointer = RESET_ZERO;
    end
  end

  // asynchronous reset is the power-on case: undefined bytes come up zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.interrupt_control_second <= RESET_INTERRUPT_SECOND;
      st.interrupt_control_third <= RESET_INTERRUPT_THIRD;
    end
    else
      st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign pc_out = st.pc;
  assign port_latch_out = st.first_port_latch;
  assign port_direction_out = st.first_port_direction;

endmodule : crri_core_register_reset_init

// ### rtl/crri_pkg.sv
// Purpose: constants for the core register reset and wake-up initialisation block
// Assumes: 8-bit register port, word index addressing
// Notes: offsets are local indices of this block
package crri_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [4:0] ADDR_STACK_TOP_UPPER = 5'h00;
  localparam logic [4:0] ADDR_STACK_TOP_HIGH = 5'h01;
  localparam logic [4:0] ADDR_STACK_TOP_LOW = 5'h02;
  localparam logic [4:0] ADDR_RETURN_STACK_POINTER = 5'h03;
  localparam logic [4:0] ADDR_PC_UPPER_LATCH = 5'h04;
  localparam logic [4:0] ADDR_PC_HIGH_LATCH = 5'h05;
  localparam logic [4:0] ADDR_PC_LOW_BYTE = 5'h06;
  localparam logic [4:0] ADDR_TABLE_POINTER_UPPER = 5'h07;
  localparam logic [4:0] ADDR_TABLE_POINTER_HIGH = 5'h08;
  localparam logic [4:0] ADDR_TABLE_POINTER_LOW = 5'h09;
  localparam logic [4:0] ADDR_TABLE_DATA_LATCH = 5'h0A;
  localparam logic [4:0] ADDR_MULTIPLY_RESULT_HIGH = 5'h0B;
  localparam logic [4:0] ADDR_MULTIPLY_RESULT_LOW = 5'h0C;
  localparam logic [4:0] ADDR_INTERRUPT_CONTROL_MAIN = 5'h0D;
  localparam logic [4:0] ADDR_INTERRUPT_CONTROL_SECOND = 5'h0E;
  localparam logic [4:0] ADDR_INTERRUPT_CONTROL_THIRD = 5'h0F;
  localparam logic [4:0] ADDR_POINTER_ZERO_HIGH = 5'h10;
  localparam logic [4:0] ADDR_POINTER_ZERO_LOW = 5'h11;
  localparam logic [4:0] ADDR_WORKING_ACCUMULATOR = 5'h12;
  localparam logic [4:0] ADDR_INDIRECT_ACCESS_ZERO = 5'h13;
  localparam logic [4:0] ADDR_INDIRECT_OFFSET_INDEXED_ZERO = 5'h17;
  localparam logic [4:0] ADDR_FIRST_PORT_INPUT = 5'h18;
  localparam logic [4:0] ADDR_FIRST_PORT_LATCH = 5'h19;
  localparam logic [4:0] ADDR_FIRST_PORT_DIRECTION = 5'h1A;
  localparam logic [7:0] MASK_5BIT = 8'h1F;
  localparam logic [7:0] MASK_6BIT = 8'h3F;
  localparam logic [7:0] MASK_4BIT = 8'h0F;
  localparam logic [7:0] MASK_STACK_POINTER = 8'hDF;
  localparam logic [7:0] MASK_PORT_NARROW = 8'h3F;
  localparam logic [7:0] STACK_FLAGS_MASK = 8'hC0;
  localparam logic [7:0] STACK_INDEX_MASK = 8'h1F;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_INTERRUPT_SECOND = 8'hFF;
  localparam logic [7:0] RESET_INTERRUPT_THIRD = 8'hC0;
  localparam logic [7:0] INTERRUPT_MAIN_KEEP_MASK = 8'h01;
  localparam int GLOBAL_HIGH_ENABLE_BIT = 7;
  localparam int GLOBAL_LOW_ENABLE_BIT = 6;
  localparam logic [20:0] VECTOR_HIGH = 21'h000008;
  localparam logic [20:0] VECTOR_LOW = 21'h000018;
  localparam logic [20:0] SLEEP_STEP = 21'h000002;
endpackage : crri_pkg

// ### verification/crri_props.sv
// Purpose: port-level assertions for the core register init block
// Assumes: bound to the top module, one clock domain
// Notes: global enables are internal, so vector checks accept either outcome
`timescale 1ns/10ps
module crri_props
  import crri_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic power_reset, // power event
  input wire logic hard_reset, // hard reset event
  input wire logic wake_watchdog, // watchdog wake
  input wire logic wake_interrupt, // interrupt wake
  input wire logic wake_high_priority, // vector select
  input wire logic [20:0] pc_current, // sleep address
  input wire logic osc_frees_pins, // port bits 7:6 usable
  input wire logic [4:0] reg_addr, // register index
  input wire logic reg_read, // read strobe
  input wire logic reg_write, // write strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [20:0] pc_out // program counter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_reset;
    power_reset || hard_reset;
  endsequence
  // a write in the cycle after the event could legally change the register read back
  sequence s_reset_quiet;
    s_reset ##1 !reg_write;
  endsequence
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_alias_zero: assert property (reg_read && reg_addr >= ADDR_INDIRECT_ACCESS_ZERO &&
    reg_addr <= ADDR_INDIRECT_OFFSET_INDEXED_ZERO |=> reg_rdata == 8'h00)
    else $error("alias location returned data");
  a_unmapped_zero: assert property (reg_read && reg_addr > ADDR_FIRST_PORT_DIRECTION
    |=> reg_rdata == 8'h00) else $error("unmapped index returned data");
  a_sp_bit_five: assert property (reg_read && reg_addr == ADDR_RETURN_STACK_POINTER
    |=> !reg_rdata[5]) else $error("stack pointer bit 5 set");
  a_port_narrow: assert property (reg_read && !osc_frees_pins &&
    reg_addr >= ADDR_FIRST_PORT_INPUT && reg_addr <= ADDR_FIRST_PORT_DIRECTION
    |=> reg_rdata[7:6] == 2'b00) else $error("port bits 7:6 visible");
  a_stack_top_clear: assert property (s_reset_quiet ##1 (reg_read &&
    reg_addr <= ADDR_STACK_TOP_LOW) |=> reg_rdata == 8'h00) else $error("stack top not clear");
  a_int_second_ones: assert property (s_reset_quiet ##1 (reg_read &&
    reg_addr == ADDR_INTERRUPT_CONTROL_SECOND) |=> reg_rdata == RESET_INTERRUPT_SECOND)
    else $error("second control not all ones");
  a_int_third_init: assert property (s_reset_quiet ##1 (reg_read &&
    reg_addr == ADDR_INTERRUPT_CONTROL_THIRD) |=> reg_rdata == RESET_INTERRUPT_THIRD)
    else $error("third control wrong after reset");
  a_pc_reset_zero: assert property (s_reset |=> pc_out == 21'h000000)
    else $error("pc not cleared by reset");
  a_watchdog_step: assert property (wake_watchdog && !wake_interrupt && !power_reset &&
    !hard_reset |=> pc_out == $past(pc_current) + SLEEP_STEP) else $error("watchdog wake pc");
  a_int_vector: assert property (wake_interrupt && !power_reset && !hard_reset
    |=> pc_out == $past(pc_current) + SLEEP_STEP ||
    pc_out == ($past(wake_high_priority) ? VECTOR_HIGH : VECTOR_LOW))
    else $error("interrupt wake pc");
endmodule : crri_props
bind crri_core_register_reset_init crri_props i_crri_props (.clk(clk), .rstn(rstn),
  .power_reset(power_reset), .hard_reset(hard_reset), .wake_watchdog(wake_watchdog),
  .wake_interrupt(wake_interrupt), .wake_high_priority(wake_high_priority),
  .pc_current(pc_current), .osc_frees_pins(osc_frees_pins), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_write(reg_write), .reg_rdata(reg_rdata), .pc_out(pc_out));

// ### verification/crri_core_register_reset_init_bench.sv
// Purpose: self-checking bench for the core register init block
// Assumes: 50 MHz clock, strobes driven right after rising edges
// Notes: undefined power-up contents are checked as the zero the design picks
`timescale 1ns/10ps
module crri_core_register_reset_init_bench;
  import crri_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic power_reset = 1'b0, hard_reset = 1'b0, wake_watchdog = 1'b0, wake_interrupt = 1'b0;
  logic wake_high_priority = 1'b0, osc_frees_pins = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] wake_flags = 8'h00, first_port_pins = 8'h00, reg_wdata = 8'h00;
  logic [20:0] pc_current = 21'h000000;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_rdata, port_latch_out, port_direction_out;
  logic [20:0] pc_out;
  int mismatches = 0;
  int compares = 0;
  // writable bits of indices 0x00..0x12
  logic [7:0] wmask [19] = '{8'h1F, 8'hFF, 8'hFF, 8'hDF, 8'h1F, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
  crri_core_register_reset_init i_crri_core_register_reset_init (.clk(clk), .rstn(rstn),
    .power_reset(power_reset), .hard_reset(hard_reset), .wake_watchdog(wake_watchdog),
    .wake_interrupt(wake_interrupt), .wake_high_priority(wake_high_priority),
    .wake_flags(wake_flags), .pc_current(pc_current), .osc_frees_pins(osc_frees_pins),
    .first_port_pins(first_port_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pc_out(pc_out),
    .port_latch_out(port_latch_out), .port_direction_out(port_direction_out));
  always #10 clk = ~clk;
  // class 0 power-up, 1 power event, 2 hard reset; 1 and 2 follow an all-ones fill
  function automatic logic [7:0] exp_of(input int i, input int cls);
    if (i == 14) return RESET_INTERRUPT_SECOND;
    if (i == 15) return RESET_INTERRUPT_THIRD;
    if (cls == 0 || i <= 10) return (cls == 1 && i == 3) ? STACK_FLAGS_MASK : 8'h00;
    return (i == 13) ? 8'h01 : wmask[i];
  endfunction : exp_of
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk("rdata", {13'h0, e}, {13'h0, reg_rdata});
  endtask : rd
  // pulse bits: 0 power, 1 hard, 2 watchdog wake, 3 interrupt wake
  task automatic ev(input logic [3:0] k);
    @(posedge clk);
    {wake_interrupt, wake_watchdog, hard_reset, power_reset} <= k;
    @(posedge clk);
    {wake_interrupt, wake_watchdog, hard_reset, power_reset} <= 4'h0;
    #1;
  endtask : ev
  task automatic finish_test;
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    #1000000;
    mismatches++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 19; i++) rd(i[4:0], exp_of(i, 0));
    wr(ADDR_INDIRECT_ACCESS_ZERO, 8'hA5);
    for (int i = 19; i < 32; i++) if (i < 24 || i > 26) rd(i[4:0], 8'h00);
    for (int c = 1; c < 3; c++)
    begin
      for (int i = 0; i < 19; i++) wr(i[4:0], 8'hFF);
      chk("pc_out", 21'h1FFFFF, pc_out);
      for (int i = 0; i < 19; i++) rd(i[4:0], wmask[i]);
      ev(c == 1 ? 4'h1 : 4'h2);
      chk("pc_out", 21'h000000, pc_out);
      for (int i = 0; i < 19; i++) rd(i[4:0], exp_of(i, c));
    end
    wr(ADDR_TABLE_POINTER_HIGH, 8'h5A);
    wr(ADDR_INTERRUPT_CONTROL_SECOND, 8'h12);
    wr(ADDR_INTERRUPT_CONTROL_MAIN, 8'h80);
    pc_current <= 21'h012344;
    wake_high_priority <= 1'b1;
    wake_flags <= 8'h04;
    ev(4'h8);
    chk("pc_out", VECTOR_HIGH, pc_out);
    rd(ADDR_STACK_TOP_UPPER, 8'h01);
    rd(ADDR_STACK_TOP_HIGH, 8'h23);
    rd(ADDR_STACK_TOP_LOW, 8'h44);
    rd(ADDR_RETURN_STACK_POINTER, 8'h01);
    rd(ADDR_INTERRUPT_CONTROL_MAIN, 8'h84);
    rd(ADDR_TABLE_POINTER_HIGH, 8'h5A);
    rd(ADDR_INTERRUPT_CONTROL_SECOND, 8'h12);
    rd(ADDR_INTERRUPT_CONTROL_THIRD, 8'hC0);
    wr(ADDR_INTERRUPT_CONTROL_MAIN, 8'h40);
    wake_high_priority <= 1'b0;
    wake_flags <= 8'h00;
    pc_current <= 21'h1ABCDE;
    ev(4'h8);
    chk("pc_out", VECTOR_LOW, pc_out);
    rd(ADDR_RETURN_STACK_POINTER, 8'h02);
    rd(ADDR_STACK_TOP_UPPER, 8'h1A);
    wr(ADDR_INTERRUPT_CONTROL_MAIN, 8'h00);
    ev(4'h8);
    chk("pc_out", 21'h1ABCE0, pc_out);
    rd(ADDR_PC_LOW_BYTE, 8'hE0);
    rd(ADDR_RETURN_STACK_POINTER, 8'h02);
    rd(ADDR_STACK_TOP_LOW, 8'hDE);
    wr(ADDR_INTERRUPT_CONTROL_MAIN, 8'h80);
    ev(4'h4);
    chk("pc_out", 21'h1ABCE0, pc_out);
    rd(ADDR_RETURN_STACK_POINTER, 8'h02);
    first_port_pins <= 8'hC5;
    wr(ADDR_FIRST_PORT_LATCH, 8'hFF);
    rd(ADDR_FIRST_PORT_LATCH, 8'h3F);
    chk("port_latch_out", 21'h00003F, {13'h0, port_latch_out});
    rd(ADDR_FIRST_PORT_INPUT, 8'h05);
    osc_frees_pins <= 1'b1;
    wr(ADDR_FIRST_PORT_DIRECTION, 8'hFF);
    rd(ADDR_FIRST_PORT_DIRECTION, 8'hFF);
    chk("port_direction_out", 21'h0000FF, {13'h0, port_direction_out});
    rd(ADDR_FIRST_PORT_INPUT, 8'hC5);
    // taking the pins back must drop the upper direction bits, not only hide them
    osc_frees_pins <= 1'b0;
    rd(ADDR_FIRST_PORT_DIRECTION, 8'h3F);
    chk("port_direction_out", 21'h00003F, {13'h0, port_direction_out});
    wr(ADDR_INTERRUPT_CONTROL_THIRD, 8'h3F);
    ev(4'h2);
    rd(ADDR_INTERRUPT_CONTROL_SECOND, 8'hFF);
    ev(4'h1);
    rd(ADDR_INTERRUPT_CONTROL_THIRD, 8'hC0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_INTERRUPT_CONTROL_SECOND, 8'hFF);
    finish_test;
  end
endmodule : crri_core_register_reset_init_bench
